// File: bench/tb_usb_ep0_in_endpoint_csr.sv
`timescale 1ns/100ps
`include "uep_params.svh"
`define chk(a, b) begin num_checks++; if ((a) !== (b)) begin mismatches++; \
  $display("Error at %0t: got %h expected %h", $time, (a), (b)); end end
module tb_usb_ep0_in_endpoint_csr;
  logic hclk, hresetn, hsel, hwrite, hreadyout, busy, ep0_stall_req, ep0_tx_ready, ep0_data_end;
  logic [1:0] htrans;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [9:0] ev;
  logic [5:1] tok_req, in_token, in_ack, in_toggle;
  logic [3:0] ack_wait;
  logic [14:0] in_resp;
  logic [39:0] in_max_pkt;
  logic [5:0] irq_flags;
  logic [2:0] seen_resp;
  int mismatches, num_checks;
  uep_csr #(.NUM_IN(5)) u_dut (.hclk(hclk), .hresetn(hresetn), .ce(1'b1), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(),
    .ep0_rx_pkt(ev[0]), .ep0_abort(ev[1]), .ep0_tx_done(ev[2]), .ep0_stall_sent(ev[3]),
    .ep0_status_done(ev[4]), .ep0_stall_req(ep0_stall_req), .ep0_tx_ready(ep0_tx_ready),
    .ep0_data_end(ep0_data_end), .ep0_fifo_flush(), .in_token(in_token), .in_ack(in_ack),
    .in_load(ev[9:5]), .in_resp(in_resp), .in_toggle(in_toggle), .in_fifo_flush(),
    .in_max_pkt(in_max_pkt), .irq_flags(irq_flags));
  uep_host_model u_host (.hclk(hclk), .hresetn(hresetn), .tok_req(tok_req),
    .ack_wait(ack_wait), .in_resp(in_resp), .in_token(in_token), .in_ack(in_ack),
    .seen_resp(seen_resp), .busy(busy));
  // Clock at 40 MHz
  initial begin
    hclk = 1'b0;
    forever #12.5 hclk = ~hclk;
  end
  task automatic finish_test();
    $display("Checks %0d, mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // Ends the run when a bounded wait ran out
  task automatic bound(input logic ok);
    if (!ok) begin
      mismatches++;
      $display("Error at %0t: wait ran out", $time);
      finish_test();
    end
  endtask
  task automatic wait_ready();
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 40);
    bound(hreadyout === 1'b1);
  endtask
  // One single AHB-Lite transfer of a word
  task automatic bus(input logic [15:0] idx, input logic is_wr, input logic [7:0] wd);
    haddr <= {14'h0000, idx, 2'h0};
    hwrite <= is_wr;
    htrans <= 2'h2;
    wait_ready();
    htrans <= 2'h0;
    hwdata <= {24'h000000, wd};
    wait_ready();
    rd = hrdata;
  endtask
  task automatic wr(input logic [15:0] idx, input logic [7:0] wd);
    bus(idx, 1'b1, wd);
  endtask
  task automatic rchk(input logic [15:0] idx, input logic [7:0] exp);
    bus(idx, 1'b0, 8'h00);
    `chk(rd, {24'h000000, exp})
  endtask
  // One-cycle engine event pulse
  task automatic pulse(input logic [9:0] m);
    ev <= m;
    @(posedge hclk);
    ev <= 10'h000;
    @(posedge hclk);
  endtask
  // Host token, then wait until the transaction is over
  task automatic token(input logic [5:1] m);
    int n;
    tok_req <= m;
    @(posedge hclk);
    tok_req <= 5'h00;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (busy !== 1'b0 && n < 40);
    bound(busy === 1'b0);
  endtask
  // Main sequence
  initial begin
    {hresetn, hwrite, htrans, haddr, hwdata, ev, tok_req, ack_wait} = '0;
    hsel = 1'b1;
    mismatches = 0;
    num_checks = 0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rchk(`UEP_IDX_IIE, 8'h3f);
    rchk(`UEP_IDX_CSR, 8'h00);
    rchk(`UEP_IDX_MAXI, 8'h00);
    rchk(16'hde30, 8'h00);
    wr(`UEP_IDX_SEL, 8'h01);
    wr(`UEP_IDX_MAXI, 8'h40);
    wr(`UEP_IDX_SEL, 8'h02);
    wr(`UEP_IDX_MAXI, 8'h10);
    rchk(`UEP_IDX_MAXI, 8'h10);
    wr(`UEP_IDX_SEL, 8'h06);
    wr(`UEP_IDX_MAXI, 8'h77);
    rchk(`UEP_IDX_MAXI, 8'h00);
    `chk(in_max_pkt[15:0], 16'h1040)
    // Control endpoint flags and strobes
    wr(`UEP_IDX_SEL, 8'h00);
    pulse(10'h001);
    rchk(`UEP_IDX_CSR, 8'h01);
    `chk(irq_flags[0], 1'b1)
    rchk(`UEP_IDX_IIF, 8'h01);
    rchk(`UEP_IDX_IIF, 8'h00);
    wr(`UEP_IDX_CSR, 8'h40);
    rchk(`UEP_IDX_CSR, 8'h00);
    pulse(10'h002);
    wr(`UEP_IDX_CSR, 8'h00);
    rchk(`UEP_IDX_CSR, 8'h10);
    wr(`UEP_IDX_CSR, 8'h80);
    rchk(`UEP_IDX_CSR, 8'h00);
    wr(`UEP_IDX_CSR, 8'h20);
    `chk(ep0_stall_req, 1'b1)
    pulse(10'h008);
    rchk(`UEP_IDX_CSR, 8'h04);
    wr(`UEP_IDX_CSR, 8'h00);
    bus(`UEP_IDX_IIF, 1'b0, 8'h00);
    wr(`UEP_IDX_CSR, 8'h0a);
    `chk({ep0_tx_ready, ep0_data_end}, 2'b11)
    pulse(10'h004);
    rchk(`UEP_IDX_CSR, 8'h08);
    rchk(`UEP_IDX_IIF, 8'h01);
    pulse(10'h010);
    rchk(`UEP_IDX_CSR, 8'h00);
    wr(`UEP_IDX_IIE, 8'h00);
    pulse(10'h001);
    rchk(`UEP_IDX_IIF, 8'h00);
    wr(`UEP_IDX_CSR, 8'h40);
    wr(`UEP_IDX_IIE, 8'h3f);
    // Bulk IN endpoint: NAK, data, toggle, stall, flush
    wr(`UEP_IDX_SEL, 8'h01);
    token(5'h01);
    `chk(seen_resp, uep_pkg::UEP_RESP_NAK)
    rchk(`UEP_IDX_CSR, 8'h04);
    wr(`UEP_IDX_CSR, 8'h00);
    pulse(10'h020);
    rchk(`UEP_IDX_CSR, 8'h02);
    bus(`UEP_IDX_IIF, 1'b0, 8'h00);
    wr(`UEP_IDX_CSR, 8'h01);
    ack_wait <= 4'h5;
    token(5'h01);
    `chk(seen_resp, uep_pkg::UEP_RESP_DATA)
    `chk(in_toggle[1], 1'b1)
    rchk(`UEP_IDX_CSR, 8'h00);
    rchk(`UEP_IDX_IIF, 8'h02);
    wr(`UEP_IDX_CSR, 8'h40);
    `chk(in_toggle[1], 1'b0)
    rchk(`UEP_IDX_CSR, 8'h00);
    pulse(10'h020);
    wr(`UEP_IDX_CSR, 8'h11);
    ack_wait <= 4'h0;
    token(5'h01);
    `chk(seen_resp, uep_pkg::UEP_RESP_STALL)
    rchk(`UEP_IDX_CSR, 8'h30);
    wr(`UEP_IDX_CSR, 8'h00);
    pulse(10'h020);
    wr(`UEP_IDX_CSR, 8'h01);
    wr(`UEP_IDX_CSR, 8'h08);
    rchk(`UEP_IDX_CSR, 8'h00);
    // Isochronous IN endpoint ignores stall, underruns
    wr(`UEP_IDX_SEL, 8'h02);
    wr(`UEP_IDX_CSIH, 8'h40);
    wr(`UEP_IDX_CSR, 8'h10);
    token(5'h02);
    `chk(seen_resp, uep_pkg::UEP_RESP_ZLP)
    rchk(`UEP_IDX_CSR, 8'h14);
    finish_test();
  end
endmodule

// File: bench/uep_csr_chk.sv
`timescale 1ns/100ps
module uep_csr_chk #(
  parameter int NUM_IN = 5
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic ep0_abort,
  input wire logic ep0_tx_done,
  input wire logic ep0_stall_sent,
  input wire logic ep0_stall_req,
  input wire logic ep0_tx_ready,
  input wire logic ep0_data_end,
  input wire logic ep0_fifo_flush,
  input wire logic [NUM_IN:1] in_token,
  input wire logic [NUM_IN:1] in_ack,
  input wire logic [3*NUM_IN-1:0] in_resp,
  input wire logic [NUM_IN:1] in_toggle,
  input wire logic [8*NUM_IN-1:0] in_max_pkt,
  input wire logic [NUM_IN:1] in_fifo_flush
);
  logic take;
  default clocking dcb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  // Address phase accepted by the slave
  assign take = hsel && htrans[1] && hready && ce;
  // Bus timing, engine events and endpoint 1 answers
  AST_BUS_WAIT: assert property (take |=> !hreadyout ##1 hreadyout)
    else $error("bus wait state wrong");
  AST_ABORT_FLUSH: assert property (ep0_abort && ce |=> ep0_fifo_flush)
    else $error("no flush after abort");
  AST_FLUSH_CAUSE: assert property (ep0_fifo_flush |-> $past(ep0_abort))
    else $error("flush without abort");
  AST_ABORT_END: assert property (ep0_abort && hreadyout |=> !ep0_data_end && !ep0_tx_ready)
    else $error("abort left ready bits");
  AST_STALL_DONE: assert property (ep0_stall_sent && hreadyout |=> !ep0_stall_req)
    else $error("stall request kept");
  AST_TX_DONE: assert property (ep0_tx_done && hreadyout |=> !ep0_tx_ready)
    else $error("tx ready kept");
  AST_IN_ANSWER: assert property (in_token[1] && ce |=> in_resp[2:0] != 3'h0)
    else $error("token not answered");
  AST_IN_CAUSE: assert property (in_resp[2:0] != 3'h0 |-> $past(in_token[1]))
    else $error("answer without token");
  AST_TOG_CAUSE: assert property (!$stable(in_toggle[1]) |-> $past(in_ack[1]) || !$past(hreadyout))
    else $error("toggle moved alone");
  AST_MAX_CAUSE: assert property (!$stable(in_max_pkt) |-> !$past(hreadyout))
    else $error("size moved alone");
  AST_IN_STALL_FLUSH: assert property (in_resp[2:0] == 3'h3 |-> in_fifo_flush[1])
    else $error("stall without flush");
  // Main scenarios reached
  COV_FLUSH: cover property (ep0_fifo_flush);
  COV_STALL: cover property (in_resp[2:0] == 3'h3);
  COV_ZLP: cover property (in_resp[5:3] == 3'h4);
endmodule

bind uep_csr uep_csr_chk #(.NUM_IN(NUM_IN)) u_chk (.hclk(hclk), .hresetn(hresetn), .ce(ce),
  .hsel(hsel), .htrans(htrans), .hready(hready), .hreadyout(hreadyout), .ep0_abort(ep0_abort),
  .ep0_tx_done(ep0_tx_done), .ep0_stall_sent(ep0_stall_sent), .ep0_stall_req(ep0_stall_req),
  .ep0_tx_ready(ep0_tx_ready), .ep0_data_end(ep0_data_end), .ep0_fifo_flush(ep0_fifo_flush),
  .in_token(in_token), .in_ack(in_ack), .in_resp(in_resp), .in_toggle(in_toggle),
  .in_max_pkt(in_max_pkt), .in_fifo_flush(in_fifo_flush));

// File: bench/uep_host_model.sv
`timescale 1ns/100ps
module uep_host_model (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [5:1] tok_req,
  input wire logic [3:0] ack_wait,
  input wire logic [14:0] in_resp,
  output logic [5:1] in_token,
  output logic [5:1] in_ack,
  output logic [2:0] seen_resp,
  output logic busy
);
  logic [5:1] ack_ep;
  logic [3:0] wait_cnt;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      in_token <= 5'h00;
      in_ack <= 5'h00;
      ack_ep <= 5'h00;
      wait_cnt <= 4'h0;
      seen_resp <= 3'h0;
    end else begin
      in_token <= tok_req;
      in_ack <= 5'h00;
      if (ack_ep != 5'h00) begin
        wait_cnt <= wait_cnt - 4'h1;
        if (wait_cnt == 4'h0) begin
          in_ack <= ack_ep;
          ack_ep <= 5'h00;
        end
      end
      for (int i = 1; i <= 5; i++) begin
        if (in_resp[3*i-1 -: 3] != 3'h0) begin
          seen_resp <= in_resp[3*i-1 -: 3];
        end
        if (in_resp[3*i-1 -: 3] == 3'h1) begin
          ack_ep[i] <= 1'b1;
          wait_cnt <= ack_wait;
        end
      end
    end
  end
  // Transaction still in flight
  assign busy = (tok_req | in_token | in_ack | ack_ep) != 5'h00 || in_resp != 15'h0000;
endmodule

// File: inc/uep_params.svh
`ifndef UEP_PARAMS_SVH
`define UEP_PARAMS_SVH
// Register indices; byte address is four times the index
`define UEP_IDX_IIF 16'hde02
`define UEP_IDX_IIE 16'hde07
`define UEP_IDX_SEL 16'hde0e
`define UEP_IDX_MAXI 16'hde10
`define UEP_IDX_CSR 16'hde11
`define UEP_IDX_CSIH 16'hde12
// Endpoint 0 control/status bits
`define UEP_B0_ABORT_CLR 7
`define UEP_B0_RX_CLR 6
`define UEP_B0_STALL_REQ 5
`define UEP_B0_ABORT 4
`define UEP_B0_DATA_END 3
`define UEP_B0_STALL_SENT 2
`define UEP_B0_TX_READY 1
`define UEP_B0_RX_READY 0
// IN endpoint control/status bits
`define UEP_BI_TOG_RST 6
`define UEP_BI_STALL_SENT 5
`define UEP_BI_STALL_REQ 4
`define UEP_BI_FLUSH 3
`define UEP_BI_UNDERRUN 2
`define UEP_BI_NONEMPTY 1
`define UEP_BI_TX_READY 0
`define UEP_BI_ISO 6
`define UEP_BI_DBL 0
// Reset values
`define UEP_RST_BYTE 8'h00
`define UEP_RST_IIE 6'h3f
`endif

// File: inc/uep_pkg.sv
package uep_pkg;
  // Answer given to an IN token
  typedef enum logic [2:0] {
    UEP_RESP_NONE,
    UEP_RESP_DATA,
    UEP_RESP_NAK,
    UEP_RESP_STALL,
    UEP_RESP_ZLP
  } uep_resp_t;
endpackage

// File: rtl/uep_csr.sv
`timescale 1ns/100ps
`include "uep_params.svh"
module uep_csr #(
  parameter int NUM_IN = 5
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic ep0_rx_pkt,
  input wire logic ep0_abort,
  input wire logic ep0_tx_done,
  input wire logic ep0_stall_sent,
  input wire logic ep0_status_done,
  output logic ep0_stall_req,
  output logic ep0_tx_ready,
  output logic ep0_data_end,
  output logic ep0_fifo_flush,
  input wire logic [NUM_IN:1] in_token,
  input wire logic [NUM_IN:1] in_ack,
  input wire logic [NUM_IN:1] in_load,
  output logic [3*NUM_IN-1:0] in_resp,
  output logic [NUM_IN:1] in_toggle,
  output logic [NUM_IN:1] in_fifo_flush,
  output logic [8*NUM_IN-1:0] in_max_pkt,
  output logic [NUM_IN:0] irq_flags
);
  // Bus data phase state
  logic pend_r, pend_wr_r, ready_r;
  logic [15:0] pend_idx_r;
  logic [31:0] rdata_r;
  logic wr_go, rd_go;
  logic [7:0] wbyte;
  // Software-visible state
  logic [3:0] sel_r;
  logic [7:0] maxp_r [1:NUM_IN];
  logic [NUM_IN:0] iie_r;
  logic [NUM_IN:0] iif_r;
  logic [NUM_IN:0] irq_req;
  logic rx_r, abort_r, stall_req_r, data_end_r, stall_sent_r, tx_r, flush0_r;
  logic [7:0] ep0_csr;
  logic csr0_we;
  logic [NUM_IN:1] csr_we, csih_we;
  logic [7:0] in_csr [1:NUM_IN];
  logic [7:0] in_csih [1:NUM_IN];
  logic [7:0] rd_byte;
  logic ep0_irq;

  // Address phase taken on a selected NONSEQ or SEQ transfer
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pend_r <= 1'b0;
      pend_wr_r <= 1'b0;
      pend_idx_r <= 16'h0000;
      ready_r <= 1'b1;
    end else if (ce) begin
      if (hsel && htrans[1] && hready && !pend_r) begin
        pend_r <= 1'b1;
        pend_wr_r <= hwrite;
        pend_idx_r <= haddr[17:2];
        ready_r <= 1'b0;
      end else begin
        pend_r <= 1'b0;
        ready_r <= 1'b1;
      end
    end
  end

  // One wait state: write or read acts in the stall cycle
  assign wr_go = ce & pend_r & pend_wr_r;
  assign rd_go = ce & pend_r & ~pend_wr_r;
  assign wbyte = hwdata[7:0];

  assign csr0_we = wr_go & (pend_idx_r == `UEP_IDX_CSR) & (sel_r == 4'd0);

  // Per-endpoint write decode
  genvar gi;
  generate
    for (gi = 1; gi <= NUM_IN; gi++) begin : g_dec
      assign csr_we[gi] = wr_go & (pend_idx_r == `UEP_IDX_CSR) & (sel_r == 4'(gi));
      assign csih_we[gi] = wr_go & (pend_idx_r == `UEP_IDX_CSIH) & (sel_r == 4'(gi));
    end
  endgenerate

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) sel_r <= 4'h0;
    else if (wr_go && pend_idx_r == `UEP_IDX_SEL) sel_r <= wbyte[3:0];
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int i = 1; i <= NUM_IN; i++) maxp_r[i] <= `UEP_RST_BYTE;
    end else if (wr_go && pend_idx_r == `UEP_IDX_MAXI) begin
      for (int i = 1; i <= NUM_IN; i++) begin
        if (sel_r == 4'(i)) maxp_r[i] <= wbyte;
      end
    end
  end

  // Interrupt enables
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) iie_r <= (NUM_IN + 1)'(`UEP_RST_IIE);
    else if (wr_go && pend_idx_r == `UEP_IDX_IIE) iie_r <= wbyte[NUM_IN:0];
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) rx_r <= 1'b0;
    else if (ce) begin
      if (ep0_rx_pkt) rx_r <= 1'b1;
      else if (csr0_we && wbyte[`UEP_B0_RX_CLR]) rx_r <= 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) abort_r <= 1'b0;
    else if (ce) begin
      if (ep0_abort) abort_r <= 1'b1;
      else if (csr0_we && wbyte[`UEP_B0_ABORT_CLR]) abort_r <= 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) flush0_r <= 1'b0;
    else if (ce) flush0_r <= ep0_abort;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) stall_req_r <= 1'b0;
    else if (ce) begin
      if (csr0_we && wbyte[`UEP_B0_STALL_REQ]) stall_req_r <= 1'b1;
      else if (ep0_stall_sent) stall_req_r <= 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) stall_sent_r <= 1'b0;
    else if (ce) begin
      if (ep0_stall_sent) stall_sent_r <= 1'b1;
      else if (csr0_we && !wbyte[`UEP_B0_STALL_SENT]) stall_sent_r <= 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) data_end_r <= 1'b0;
    else if (ce) begin
      if (csr0_we && wbyte[`UEP_B0_DATA_END]) data_end_r <= 1'b1;
      else if (ep0_status_done || ep0_abort) data_end_r <= 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) tx_r <= 1'b0;
    else if (ce) begin
      if (csr0_we && wbyte[`UEP_B0_TX_READY]) tx_r <= 1'b1;
      else if (ep0_tx_done || ep0_abort) tx_r <= 1'b0;
    end
  end

  // strobes read as zero
  // Stall request reads back until the handshake has gone out
  assign ep0_csr = {2'b00, stall_req_r, abort_r, data_end_r, stall_sent_r, tx_r, rx_r};
  assign ep0_irq = ep0_rx_pkt | ep0_abort | ep0_tx_done | ep0_stall_sent;
  assign irq_req[0] = ep0_irq;

  // IN endpoints
  generate
    for (gi = 1; gi <= NUM_IN; gi++) begin : g_in
      uep_pkg::uep_resp_t resp_w;
      uep_in_ep u_ep (
        .hclk(hclk),
        .hresetn(hresetn),
        .ce(ce),
        .csr_we(csr_we[gi]),
        .csih_we(csih_we[gi]),
        .wdata(wbyte),
        .in_token(in_token[gi]),
        .in_ack(in_ack[gi]),
        .in_load(in_load[gi]),
        .csr(in_csr[gi]),
        .csih(in_csih[gi]),
        .toggle(in_toggle[gi]),
        .resp(resp_w),
        .irq_req(irq_req[gi]),
        .fifo_flush(in_fifo_flush[gi])
      );
      assign in_resp[3*gi-1 -: 3] = resp_w;
      assign in_max_pkt[8*gi-1 -: 8] = maxp_r[gi];
    end
  endgenerate

  // flags set when enabled, cleared on read
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) iif_r <= '0;
    else if (ce) begin
      if (rd_go && pend_idx_r == `UEP_IDX_IIF) iif_r <= irq_req & iie_r;
      else iif_r <= iif_r | (irq_req & iie_r);
    end
  end

  // Read data mux
  always_comb begin
    rd_byte = 8'h00;
    case (pend_idx_r)
      `UEP_IDX_IIF: rd_byte = 8'(iif_r);
      `UEP_IDX_IIE: rd_byte = 8'(iie_r);
      `UEP_IDX_SEL: rd_byte = {4'h0, sel_r};
      default: rd_byte = 8'h00;
    endcase
    for (int i = 1; i <= NUM_IN; i++) begin
      if (sel_r == 4'(i)) begin
        if (pend_idx_r == `UEP_IDX_MAXI) rd_byte = maxp_r[i];
        if (pend_idx_r == `UEP_IDX_CSR) rd_byte = in_csr[i];
        if (pend_idx_r == `UEP_IDX_CSIH) rd_byte = in_csih[i];
      end
    end
    if (sel_r == 4'd0 && pend_idx_r == `UEP_IDX_CSR) rd_byte = ep0_csr;
  end

  // Read data register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) rdata_r <= 32'h00000000;
    else if (rd_go) rdata_r <= {24'h000000, rd_byte};
  end

  assign hrdata = rdata_r;
  assign hreadyout = ready_r;
  assign hresp = 1'b0;
  assign ep0_stall_req = stall_req_r;
  assign ep0_tx_ready = tx_r;
  assign ep0_data_end = data_end_r;
  assign ep0_fifo_flush = flush0_r;
  assign irq_flags = iif_r;
endmodule

// File: rtl/uep_in_ep.sv
`timescale 1ns/100ps
`include "uep_params.svh"
module uep_in_ep (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  input wire logic csr_we,
  input wire logic csih_we,
  input wire logic [7:0] wdata,
  input wire logic in_token,
  input wire logic in_ack,
  input wire logic in_load,
  output logic [7:0] csr,
  output logic [7:0] csih,
  output logic toggle,
  output uep_pkg::uep_resp_t resp,
  output logic irq_req,
  output logic fifo_flush
);
  logic [1:0] cnt_r;
  logic [1:0] cnt_nxt;
  logic tx_r, stall_req_r, stall_sent_r, underrun_r, tog_r, iso_r, dbl_r;
  logic tok_stall, tok_data, tok_nak, tok_zlp, sent, fw_flush;
  uep_pkg::uep_resp_t resp_r;
  logic irq_r, flush_r;

  // Token decode; stall has no effect on iso
  // stall answers token
  assign tok_stall = in_token & ~iso_r & stall_req_r;
  assign tok_data = in_token & tx_r & ~tok_stall;
  assign tok_nak = in_token & ~iso_r & ~stall_req_r & ~tx_r;
  assign tok_zlp = in_token & iso_r & ~tx_r;
  assign sent = (in_ack & ~iso_r & tx_r) | (tok_data & iso_r);
  assign fw_flush = csr_we & wdata[`UEP_BI_FLUSH];

  // Packet count, capped by buffering mode
  always_comb begin
    cnt_nxt = cnt_r;
    if (in_load && cnt_r != {1'b0, dbl_r} + 2'd1) cnt_nxt = cnt_r + 2'd1;
    if ((sent || fw_flush) && cnt_nxt != 2'd0) cnt_nxt = cnt_nxt - 2'd1;
    if (tok_stall) cnt_nxt = 2'd0;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) cnt_r <= 2'd0;
    else if (ce) cnt_r <= cnt_nxt;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) tx_r <= 1'b0;
    else if (ce) begin
      if (csr_we && wdata[`UEP_BI_TX_READY]) tx_r <= 1'b1;
      else if (sent || tok_stall || fw_flush) tx_r <= 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) stall_sent_r <= 1'b0;
    else if (ce) begin
      if (tok_stall) stall_sent_r <= 1'b1;
      else if (csr_we && !wdata[`UEP_BI_STALL_SENT]) stall_sent_r <= 1'b0;
    end
  end

  // Stall request held by firmware
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) stall_req_r <= 1'b0;
    else if (ce && csr_we) stall_req_r <= wdata[`UEP_BI_STALL_REQ];
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) underrun_r <= 1'b0;
    else if (ce) begin
      if (tok_zlp || tok_nak) underrun_r <= 1'b1;
      else if (csr_we && !wdata[`UEP_BI_UNDERRUN]) underrun_r <= 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) tog_r <= 1'b0;
    else if (ce) begin
      if (csr_we && wdata[`UEP_BI_TOG_RST]) tog_r <= 1'b0;
      else if (sent && !iso_r) tog_r <= ~tog_r;
    end
  end

  // Endpoint type and buffering
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      iso_r <= 1'b0;
      dbl_r <= 1'b0;
    end else if (ce && csih_we) begin
      iso_r <= wdata[`UEP_BI_ISO];
      dbl_r <= wdata[`UEP_BI_DBL];
    end
  end

  // Registered answer, interrupt request and flush pulse
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      resp_r <= uep_pkg::UEP_RESP_NONE;
      irq_r <= 1'b0;
      flush_r <= 1'b0;
    end else if (ce) begin
      if (tok_stall) resp_r <= uep_pkg::UEP_RESP_STALL;
      else if (tok_data) resp_r <= uep_pkg::UEP_RESP_DATA;
      else if (tok_zlp) resp_r <= uep_pkg::UEP_RESP_ZLP;
      else if (tok_nak) resp_r <= uep_pkg::UEP_RESP_NAK;
      else resp_r <= uep_pkg::UEP_RESP_NONE;
      irq_r <= sent | tok_stall;
      flush_r <= fw_flush | tok_stall;
    end
  end

  assign csr = {2'b00, stall_sent_r, stall_req_r, 1'b0, underrun_r, cnt_r != 2'd0, tx_r};
  assign csih = {1'b0, iso_r, 5'b00000, dbl_r};
  assign toggle = tog_r;
  assign resp = resp_r;
  assign irq_req = irq_r;
  assign fifo_flush = flush_r;
endmodule
